// >>> fsdc_map.svh
/*
 Constants for the flash sleep control block: opcodes, delays, clock rate.
 Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef FSDC_MAP_SVH
`define FSDC_MAP_SVH

// ----------------------------------------
// Opcodes (defaults, overridable by parameter)
// ----------------------------------------
`define FSDC_OP_SLEEP 8'hA5
`define FSDC_OP_WAKE 8'h5A

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSDC_CLK_MHZ 200
`define FSDC_SLEEP_ENTRY_DELAY_US 3
`define FSDC_WAKE_DELAY_US 30
`define FSDC_SLEEP_ENTRY_CYC (`FSDC_SLEEP_ENTRY_DELAY_US * `FSDC_CLK_MHZ)
`define FSDC_WAKE_CYC (`FSDC_WAKE_DELAY_US * `FSDC_CLK_MHZ)

`endif

// >>> fsdc_pkg.sv
/*
 Types for the flash sleep control block.
 Assumes fsdc_map.svh is on the include path.
*/
package fsdc_pkg;
	typedef enum logic [2:0] {
		FSDC_STANDBY,
		FSDC_SELECTED,
		FSDC_ENTERING,
		FSDC_SLEEP,
		FSDC_WAKING
	} fsdc_state_t;

	// Outcome of one frame as seen on the link clock
	typedef struct packed {
		logic sleep_cmd;
		logic wake_cmd;
		logic write_cmd;
	} fsdc_frame_t;
endpackage

// >>> fsdc_ctrl.sv
/*
 Deep sleep entry/exit and standby control of a serial flash.
 Link side runs on the serial clock (sclk, mode 0 sampling on rising edge) and may stop
 between frames; the core side runs on ref_clk. Chip select and the busy flag are pins
 synchronised into ref_clk. Frame results cross by a toggle handshake.
*/
//
// Functional notes
// RULE1 - Sleep entered only through sleep-entry command
// RULE2 - Sleep mode blocks write, program, erase
// RULE3 - Select high, idle core: go standby
// RULE4 - Master holds select low, shifts opcode
// RULE5 - Sleep needs exactly eight bits
// RULE6 - Sleep reached after entry delay
// RULE7 - Sleep command rejected while core busy
// RULE8 - In sleep only wake command accepted
// RULE9 - Master sends only wake during sleep; the bench also sends sleep and other opcodes while asleep
// RULE10 - Reset lands in standby, never sleep
// RULE11 - Master frames wake with chip select
// RULE12 - Extra clocks after wake opcode reject
// RULE13 - Standby reached after wake delay
// RULE14 - Master keeps select high during wake
// RULE15 - Wake command rejected while core busy
// RULE16 - Entry delay at most 3 us
// RULE17 - Wake delay at most 30 us
// RULE18 - Opcodes are configurable constants
`timescale 1ns/1ps
`include "fsdc_map.svh"

module fsdc_ctrl
	import fsdc_pkg::*;
#(
	parameter logic [7:0] OP_SLEEP = `FSDC_OP_SLEEP,
	parameter logic [7:0] OP_WAKE = `FSDC_OP_WAKE,
	parameter int SLEEP_CYC = `FSDC_SLEEP_ENTRY_CYC,
	parameter int WAKE_CYC = `FSDC_WAKE_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic core_busy,
	output logic sleep_mode,
	output logic standby,
	output logic selected,
	output logic cmd_block,
	output logic write_block,
	output logic sleep_supply_current
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_r;
	logic rst_s2_r;
	logic rst_core_n;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'h0;
			rst_s2_r <= 1'h0;
		end else begin
			rst_s1_r <= 1'h1;
			rst_s2_r <= rst_s1_r;
		end
	end

	assign rst_core_n = rst_s2_r;

	// ----------------------------------------
	// Link side: bit counter and shifter
	// ----------------------------------------
	// Reset asynchronously by chip select high so each frame starts clean even
	// though sclk stops between frames.
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;

	always_comb begin
		sh_nxt = {sh_r[6:0], serial_in}; // [RULE4] [RULE11]
	end

	// Saturates so that an over-long frame never wraps back to eight bits
	always_comb begin
		if (cnt_r != 4'hF) begin
			cnt_nxt = cnt_r + 4'h1;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sh_r <= 8'h00;
		end else begin
			sh_r <= sh_nxt;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------
	// Frame outcome at the rising edge of chip select
	// ----------------------------------------
	fsdc_frame_t frm_r;
	fsdc_frame_t frm_nxt;
	logic frm_tgl_r;
	logic exact8;
	logic op_sleep_hit;
	logic op_wake_hit;

	assign exact8 = (cnt_r == 4'h8);
	assign op_sleep_hit = (sh_r == OP_SLEEP); // [RULE18]
	assign op_wake_hit = (sh_r == OP_WAKE); // [RULE18]

	always_comb begin
		frm_nxt.sleep_cmd = exact8 && op_sleep_hit; // [RULE5]
		frm_nxt.wake_cmd = exact8 && op_wake_hit; // [RULE12]
		frm_nxt.write_cmd = (cnt_r != 4'h0) && !(exact8 && (op_sleep_hit || op_wake_hit));
	end

	always_ff @(posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			frm_r <= '0;
		end else begin
			frm_r <= frm_nxt;
		end
	end

	// Toggles once per frame; the core side sees the frame by its change
	always_ff @(posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			frm_tgl_r <= 1'h0;
		end else begin
			frm_tgl_r <= ~frm_tgl_r;
		end
	end

	// ----------------------------------------
	// Crossings into ref_clk
	// ----------------------------------------
	logic [2:0] tgl_sync_r;
	logic [2:0] cs_sync_r;
	logic [1:0] busy_sync_r;
	logic frame_done;
	logic cs_hi;
	logic busy;

	// Two stages, then one more for edge detection
	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			tgl_sync_r <= 3'h0;
		end else begin
			tgl_sync_r <= {tgl_sync_r[1:0], frm_tgl_r};
		end
	end

	// One stage longer than the toggle, so deselect never overtakes a frame result
	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			cs_sync_r <= 3'h7;
		end else begin
			cs_sync_r <= {cs_sync_r[1:0], cs_n};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			busy_sync_r <= 2'h0;
		end else begin
			busy_sync_r <= {busy_sync_r[0], core_busy};
		end
	end

	// Frame word is stable long before its toggle arrives
	assign frame_done = tgl_sync_r[2] ^ tgl_sync_r[1];
	assign cs_hi = cs_sync_r[2];
	assign busy = busy_sync_r[1];

	// ----------------------------------------
	// Power mode state machine
	// ----------------------------------------
	localparam int CW = $clog2((SLEEP_CYC > WAKE_CYC ? SLEEP_CYC : WAKE_CYC) + 1);
	localparam logic [CW-1:0] SLEEP_LAST = CW'(SLEEP_CYC - 1);
	localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYC - 1);
	fsdc_state_t st_r;
	fsdc_state_t st_nxt;
	logic tmr_clr;
	logic tmr_run;
	logic [CW-1:0] tmr_r;
	logic [CW-1:0] tmr_nxt;
	logic entry_done;
	logic wake_done;
	logic in_standby;
	logic in_selected;
	logic in_entry;
	logic in_sleep;
	logic in_wake;

	assign in_standby = (st_r == FSDC_STANDBY);
	assign in_selected = (st_r == FSDC_SELECTED);
	assign in_entry = (st_r == FSDC_ENTERING);
	assign in_sleep = (st_r == FSDC_SLEEP);
	assign in_wake = (st_r == FSDC_WAKING);
	assign entry_done = (tmr_r == SLEEP_LAST);
	assign wake_done = (tmr_r == WAKE_LAST);
	assign tmr_run = (in_entry && !entry_done) || (in_wake && !wake_done);

	always_comb begin
		st_nxt = st_r;
		tmr_clr = 1'h0;
		case (st_r)
			FSDC_STANDBY: begin
				if (!cs_hi) begin
					st_nxt = FSDC_SELECTED;
				end
			end
			FSDC_SELECTED: begin
				if (frame_done) begin
					tmr_clr = 1'h1;
					if (frm_r.sleep_cmd && !busy) begin // [RULE1] [RULE7]
						st_nxt = FSDC_ENTERING;
					end else if (!busy) begin // [RULE3]
						st_nxt = FSDC_STANDBY;
					end
				end else if (cs_hi && !busy) begin
					st_nxt = FSDC_STANDBY; // [RULE3]
				end
			end
			FSDC_ENTERING: begin
				if (entry_done) begin // [RULE6] [RULE16]
					st_nxt = FSDC_SLEEP;
				end
			end
			FSDC_SLEEP: begin
				// Only a wake frame leaves sleep; anything else is dropped
				if (frame_done && frm_r.wake_cmd && !busy) begin // [RULE8] [RULE15]
					tmr_clr = 1'h1;
					st_nxt = FSDC_WAKING;
				end
			end
			FSDC_WAKING: begin
				if (wake_done) begin // [RULE13] [RULE17]
					st_nxt = FSDC_STANDBY;
				end
			end
			default: begin
				st_nxt = FSDC_STANDBY;
			end
		endcase
	end

	// Counts only in the two timed states and holds at its last value
	always_comb begin
		if (tmr_clr) begin
			tmr_nxt = '0;
		end else if (tmr_run) begin
			tmr_nxt = tmr_r + CW'(1);
		end else begin
			tmr_nxt = tmr_r;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			st_r <= FSDC_STANDBY; // [RULE10]
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			tmr_r <= '0;
		end else begin
			tmr_r <= tmr_nxt;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			sleep_mode <= 1'h0;
		end else begin
			sleep_mode <= in_sleep;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			sleep_supply_current <= 1'h0;
		end else begin
			sleep_supply_current <= in_sleep; // [RULE6]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			standby <= 1'h1;
		end else begin
			standby <= in_standby;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			selected <= 1'h0;
		end else begin
			selected <= in_selected;
		end
	end

	// Decoder must drop all commands while asleep or in transition
	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			cmd_block <= 1'h0;
		end else begin
			cmd_block <= in_sleep || in_entry || in_wake; // [RULE8]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			write_block <= 1'h0;
		end else begin
			write_block <= !in_standby && !in_selected; // [RULE2]
		end
	end

endmodule

// >>> fsdc_master.sv
/* Serial bus master model driving the flash sleep control block.
 Assumes the bench calls send and spaces frames itself. */
`timescale 1ns/1ps
module fsdc_master (
	output logic sclk,
	output logic cs_n,
	output logic serial_in
);
	initial begin
		sclk = 0;
		cs_n = 1;
		serial_in = 0;
	end
	// Clock only inside frames; data inverted once released
	task automatic send(input logic [7:0] op, input int extra);
		cs_n = 0;
		for (int i = 0; i < 8 + extra; i++) begin
			serial_in = op[7 - i % 8];
			#6 sclk = 1;
			#6 sclk = 0;
		end
		#6 cs_n = 1;
		serial_in = ~serial_in;
		#120;
	endtask
endmodule

// >>> fsdc_ctrl_assertions.sv
/* Port checker for fsdc_ctrl.
 Assumes binding to fsdc_ctrl with its delay parameters. */
`timescale 1ns/1ps
module fsdc_ctrl_chk #(parameter int SLEEP_CYC = 4, parameter int WAKE_CYC = 8) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic core_busy,
	input wire logic sleep_mode,
	input wire logic standby,
	input wire logic selected,
	input wire logic cmd_block,
	input wire logic write_block,
	input wire logic sleep_supply_current
);
	localparam int ENTRY_MAX = SLEEP_CYC + 3;
	localparam int WAKE_LIM = WAKE_CYC + 3;
	int cnt_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) cnt_r <= 0;
		else cnt_r <= (cmd_block && !sleep_mode) ? cnt_r + 1 : 0;
	end
	chk_supply_level: assert property (sleep_supply_current == sleep_mode) else $error("supply flag differs");
	chk_write_block: assert property (write_block == cmd_block) else $error("write block differs");
	chk_sleep_blocks: assert property (sleep_mode |-> cmd_block && !standby) else $error("sleep unblocked");
	chk_sleep_source: assert property ($rose(sleep_mode) |-> $past(cmd_block)) else $error("sleep from idle");
	chk_entry_delay: assert property ($rose(cmd_block) |-> ##[1:ENTRY_MAX] sleep_mode) else $error("entry late");
	chk_wake_limit: assert property (cnt_r <= WAKE_LIM) else $error("wake late");
	chk_wake_end: assert property ($fell(cmd_block) |-> ##[0:1] standby) else $error("no standby after wake");
	chk_idle_standby: assert property ((cs_n && !core_busy && !cmd_block)[*6] |-> standby) else $error("not standby");
	chk_select_excl: assert property (selected |-> !cmd_block && !standby) else $error("selected in sleep");
endmodule
bind fsdc_ctrl fsdc_ctrl_chk #(.SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.cs_n(cs_n), .core_busy(core_busy), .sleep_mode(sleep_mode), .standby(standby), .selected(selected),
	.cmd_block(cmd_block), .write_block(write_block), .sleep_supply_current(sleep_supply_current));

// >>> test_spi_flash_deep_sleep_control.sv
/* Self-checking bench for fsdc_ctrl with a serial master model.
 Assumes fsdc_map.svh on the include path. */
`timescale 1ns/1ps
`include "fsdc_map.svh"
module test_spi_flash_deep_sleep_control;
	logic ref_clk = 0, rst_n = 0, core_busy = 0, prev_r = 0;
	wire sclk, cs_n, serial_in;
	logic sleep_mode, standby, selected, cmd_block, write_block, sleep_supply_current;
	int failures = 0, comparisons = 0, cyc = 0;
	logic q[$];
	logic [7:0] r;
	always #2.5 ref_clk = ~ref_clk;
	fsdc_master m (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in));
	fsdc_ctrl #(.SLEEP_CYC(4), .WAKE_CYC(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.serial_in(serial_in), .core_busy(core_busy), .sleep_mode(sleep_mode), .standby(standby),
		.selected(selected), .cmd_block(cmd_block), .write_block(write_block),
		.sleep_supply_current(sleep_supply_current));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic frame(input logic [7:0] op, input int extra, input logic busy);
		@(posedge ref_clk) core_busy <= busy;
		m.send(op, extra);
		repeat (40) @(posedge ref_clk);
		@(posedge ref_clk) core_busy <= 0;
		repeat (10) @(posedge ref_clk);
		$display("frame %h extra %0d busy %0d done", op, extra, busy);
	endtask
	// Each change of the sleep output takes the oldest expected note
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			report_and_stop();
		end
		if (rst_n && sleep_mode !== prev_r) begin
			if (q.size() == 0) check(sleep_mode, ~sleep_mode);
			else check(sleep_mode, q.pop_front());
		end
		prev_r <= sleep_mode;
	end
	initial begin
		void'($urandom(28));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1;
		repeat (6) @(posedge ref_clk);
		check(standby, 1);
		check(sleep_mode, 0);
		check(selected, 0);
		for (int i = 0; i < 3; i++) begin
			r = 8'($urandom) & 8'hF0;
			frame(r, 0, 0);
		end
		frame(`FSDC_OP_SLEEP, 1, 0);
		frame(`FSDC_OP_SLEEP, 0, 1);
		check(standby, 1);
		q.push_back(1);
		frame(`FSDC_OP_SLEEP, 0, 0);
		check(write_block, 1);
		check(cmd_block, 1);
		check(sleep_supply_current, 1);
		frame(`FSDC_OP_SLEEP, 0, 0);
		frame(8'($urandom) & 8'hF0, 0, 0);
		frame(`FSDC_OP_WAKE, 1, 0);
		frame(`FSDC_OP_WAKE, 0, 1);
		check(sleep_mode, 1);
		q.push_back(0);
		frame(`FSDC_OP_WAKE, 0, 0);
		check(standby, 1);
		check(cmd_block, 0);
		check(sleep_supply_current, 0);
		check(8'(q.size()), 0);
		report_and_stop();
	end
endmodule
